// [hdl/pgr_ctrl.sv]
`timescale 1ns/1ps
module pgr_ctrl
  import pgr_pkg::*;
#(
  parameter int unsigned LOW_CYC = LOW_QUAL_CYC,
  parameter int unsigned HIGH_CYC = HIGH_QUAL_CYC,
  parameter int unsigned PARK_TO_CYC = PARK_TIMEOUT_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic supply_good_in,
  input wire logic supply_on_sense_in,
  input wire logic active_sel_in,
  input wire logic park_done,
  output logic park_req,
  output logic ctrl_reset,
  output logic active_mode,
  output logic supply_on_sense,
  output pgr_pkg::pgr_state_t state
);
  import pgr_pkg::*;

  // ==========================================================
  // input synchronisers
  logic good_s;
  logic sense_s;
  logic sel_s;

  // synchronise the three pins
  pgr_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b0)) u_good (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(supply_good_in),
    .sync_out(good_s)
  );
  pgr_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b0)) u_sense (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(supply_on_sense_in),
    .sync_out(sense_s)
  );
  pgr_sync #(.STAGES(SYNC_STAGES), .RST_VAL(1'b0)) u_sel (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(active_sel_in),
    .sync_out(sel_s)
  );

  // ==========================================================
  // qualification counters and sequencer
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;
  pgr_state_t st_reg;
  pgr_state_t st_next;
  logic park_reg;
  logic park_next;
  logic crst_reg;
  logic crst_next;
  logic act_reg;
  logic act_next;
  logic sense_reg;
  logic sense_next;

  localparam logic [CNT_W-1:0] LOW_LAST = CNT_W'(LOW_CYC - 1);
  localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(HIGH_CYC - 1);
  localparam logic [CNT_W-1:0] PARK_LAST = CNT_W'(PARK_TO_CYC - 1);

  // next state of the sequencer
  always_comb begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    case (st_reg)
      PGR_RESET: begin
        if (!good_s) begin
          cnt_next = '0;
        end else if (cnt_reg == HIGH_LAST) begin
          st_next = PGR_RUN;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      PGR_RUN: begin
        if (good_s) begin
          cnt_next = '0; // short low pulses dropped
        end else if (cnt_reg == LOW_LAST) begin
          st_next = PGR_PARK;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      PGR_PARK: begin
        if (park_done || cnt_reg == PARK_LAST) begin
          st_next = PGR_CTRL_RST; // park then reset
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + CNT_W'(1);
        end
      end
      PGR_CTRL_RST: begin
        st_next = PGR_RESET; // full reset held in reset state
        cnt_next = '0;
      end
      default: begin
        st_next = PGR_RESET;
        cnt_next = '0;
      end
    endcase
    park_next = (st_next == PGR_PARK);
    crst_next = (st_next == PGR_RESET) || (st_next == PGR_CTRL_RST);
    // active only when running and selected
    act_next = (st_next == PGR_RUN) && sel_s;
    sense_next = sense_s;
  end

  // register the sequencer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= PGR_RESET;
      cnt_reg <= '0;
      park_reg <= 1'b0;
      crst_reg <= 1'b1;
      act_reg <= 1'b0;
      sense_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      park_reg <= park_next;
      crst_reg <= crst_next;
      act_reg <= act_next;
      sense_reg <= sense_next;
    end
  end

  // outputs from flops
  assign park_req = park_reg;
  assign ctrl_reset = crst_reg;
  assign active_mode = act_reg;
  assign supply_on_sense = sense_reg;
  assign state = st_reg;

  // ==========================================================
  // assertion helper: run of high supply good samples
  logic [CNT_W-1:0] hi_run_reg;
  logic [CNT_W-1:0] hi_run_next;

  // count consecutive high samples, saturating
  always_comb begin
    hi_run_next = hi_run_reg;
    if (!good_s) begin
      hi_run_next = '0;
    end else if (hi_run_reg != '1) begin
      hi_run_next = hi_run_reg + CNT_W'(1);
    end
  end

  // register the helper count
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hi_run_reg <= '0;
    end else begin
      hi_run_reg <= hi_run_next;
    end
  end

  // ==========================================================
  // assertions
  property p_low_park;
    @(posedge core_clk) disable iff (rst)
      (st_reg == PGR_RUN && !good_s && cnt_reg == LOW_LAST) |=> park_reg;
  endproperty
  a_low_park: assert property (p_low_park) else $error("park not raised after low time");

  property p_glitch;
    @(posedge core_clk) disable iff (rst)
      (st_reg == PGR_RUN && good_s) |=> (st_reg == PGR_RUN && cnt_reg == '0);
  endproperty
  a_glitch: assert property (p_glitch) else $error("glitch not ignored");

  property p_hold_rst;
    @(posedge core_clk) disable iff (rst)
      (st_reg == PGR_RESET && !good_s) |=> (st_reg == PGR_RESET && ctrl_reset);
  endproperty
  a_hold_rst: assert property (p_hold_rst) else $error("left reset while supply low");

  property p_ack;
    @(posedge core_clk) disable iff (rst)
      $rose(st_reg == PGR_RUN) |-> $past(good_s, 1) && !ctrl_reset && (hi_run_reg > HIGH_LAST);
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledged early");

  property p_active;
    @(posedge core_clk) disable iff (rst)
      (st_next == PGR_RUN && sel_s) |=> active_mode;
  endproperty
  a_active: assert property (p_active) else $error("active mode not entered");

  property p_standby;
    @(posedge core_clk) disable iff (rst)
      !sel_s |=> !active_mode;
  endproperty
  a_standby: assert property (p_standby) else $error("standby not entered");

  property p_park_then_rst;
    @(posedge core_clk) disable iff (rst)
      (st_reg == PGR_PARK && park_done) |=> ##1 (ctrl_reset && !park_req);
  endproperty
  a_park_then_rst: assert property (p_park_then_rst) else $error("no reset after park");

  property p_sync;
    @(posedge core_clk) disable iff (rst)
      sense_reg == $past(supply_on_sense_in, 3) || $past(rst, 3);
  endproperty
  a_sync: assert property (p_sync) else $error("sense path latency wrong");
endmodule : pgr_ctrl

// [hdl/pgr_pkg.sv]
// ==========================================================
// shared constants for power-good / reset / standby control
package pgr_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // minimum low time of supply good before park (ns)
  localparam int unsigned LOW_QUAL_NS = 4000;
  // minimum high time of supply good before acknowledge (ns)
  localparam int unsigned HIGH_QUAL_NS = 625;
  localparam int unsigned NS_PER_CYCLE = 1000000000 / CLK_HZ;
  // least times round up
  localparam int unsigned LOW_QUAL_CYC = (LOW_QUAL_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int unsigned HIGH_QUAL_CYC = (HIGH_QUAL_NS + NS_PER_CYCLE - 1) / NS_PER_CYCLE;
  localparam int unsigned CNT_W = 8;
  localparam int unsigned SYNC_STAGES = 2;
  // default length of the park handshake timeout in cycles
  localparam int unsigned PARK_TIMEOUT_CYC = 255;
  typedef enum logic [2:0] {
    PGR_RESET,
    PGR_RUN,
    PGR_PARK,
    PGR_CTRL_RST
  } pgr_state_t;
endpackage : pgr_pkg

// [hdl/pgr_sync.sv]
`timescale 1ns/1ps
// ==========================================================
// two-flop synchroniser for one asynchronous level
module pgr_sync #(
  parameter int unsigned STAGES = 2,
  parameter logic RST_VAL = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);
  logic [STAGES-1:0] chain_reg;
  logic [STAGES-1:0] chain_next;

  // shift in the pin level
  always_comb begin
    chain_next = {chain_reg[STAGES-2:0], async_in};
  end

  // register the chain
  always_ff @(posedge core_clk) begin
    if (rst) begin
      chain_reg <= {STAGES{RST_VAL}};
    end else begin
      chain_reg <= chain_next;
    end
  end

  assign sync_out = chain_reg[STAGES-1]; // only the last stage is read
endmodule : pgr_sync

// [bench/pgr_supply_model.sv]
`timescale 1ns/1ps
// ==========================================================
// supply monitor model: rails and early warning
module pgr_supply_model (
  input wire logic core_clk,
  input wire logic rails_ok,
  input wire logic warn,
  output logic supply_good_in,
  output logic supply_on_sense_in
);
  // good only with rails up and no warning, sense tracks rails
  always_ff @(posedge core_clk) begin
    supply_good_in <= rails_ok && !warn;
    supply_on_sense_in <= rails_ok;
  end
endmodule : pgr_supply_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
// ==========================================================
// bench top
module tb_top;
  import pgr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic rails_ok = 1'b1;
  logic warn = 1'b1;
  logic active_sel_in = 1'b1;
  logic park_done = 1'b0;
  logic supply_good_in, supply_on_sense_in, park_req, ctrl_reset, active_mode, supply_on_sense;
  pgr_state_t state;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  pgr_supply_model mon_u (.core_clk(core_clk), .rails_ok(rails_ok), .warn(warn),
    .supply_good_in(supply_good_in), .supply_on_sense_in(supply_on_sense_in));
  pgr_ctrl dut_u (.core_clk(core_clk), .rst(rst), .supply_good_in(supply_good_in),
    .supply_on_sense_in(supply_on_sense_in), .active_sel_in(active_sel_in),
    .park_done(park_done), .park_req(park_req), .ctrl_reset(ctrl_reset),
    .active_mode(active_mode), .supply_on_sense(supply_on_sense), .state(state));
  // 50 ns clock
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  task automatic conclude;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // hang guard
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : wait_cyc
  task automatic set_warn(input logic v);
    @(posedge core_clk) warn <= v;
  endtask : set_warn
  // high pulse too short to be taken
  task automatic t_short_high;
    set_warn(1'b0);
    wait_cyc(10);
    set_warn(1'b1);
    wait_cyc(20);
    chk(ctrl_reset, 1'b1);
  endtask : t_short_high
  // power up and standby select
  task automatic t_power_up;
    set_warn(1'b0);
    wait_cyc(12);
    chk(ctrl_reset, 1'b1);
    wait_cyc(8);
    chk(ctrl_reset, 1'b0);
    chk(active_mode, 1'b1);
    chk(supply_on_sense, 1'b1);
    @(posedge core_clk) active_sel_in <= 1'b0;
    wait_cyc(6);
    chk(active_mode, 1'b0);
    @(posedge core_clk) active_sel_in <= 1'b1;
    wait_cyc(6);
    chk(active_mode, 1'b1);
  endtask : t_power_up
  // low glitch under the minimum is ignored
  task automatic t_glitch;
    set_warn(1'b1);
    wait_cyc(40);
    set_warn(1'b0);
    repeat (100) begin
      wait_cyc(1);
      chk(park_req, 1'b0);
    end
  endtask : t_glitch
  // long low parks, resets, holds reset
  task automatic t_park;
    int k;
    set_warn(1'b1);
    wait_cyc(70);
    chk(park_req, 1'b0);
    k = 0;
    while (park_req !== 1'b1 && k < 30) begin
      wait_cyc(1);
      k++;
    end
    chk(park_req, 1'b1);
    chk(supply_on_sense, 1'b1);
    @(posedge core_clk) park_done <= 1'b1;
    @(posedge core_clk) park_done <= 1'b0;
    wait_cyc(5);
    chk(park_req, 1'b0);
    chk(state == PGR_RESET, 1'b1);
    wait_cyc(50);
    chk(ctrl_reset, 1'b1);
    set_warn(1'b0);
    wait_cyc(20);
    chk(ctrl_reset, 1'b0);
  endtask : t_park
  // park never acknowledged: request times out, then reset
  task automatic t_timeout;
    int k;
    set_warn(1'b1);
    wait_cyc(70);
    k = 0;
    while (park_req !== 1'b1 && k < 30) begin
      wait_cyc(1);
      k++;
    end
    chk(park_req, 1'b1);
    wait_cyc(PARK_TIMEOUT_CYC - 1);
    chk(park_req, 1'b1);
    wait_cyc(1);
    chk(park_req, 1'b0);
    chk(ctrl_reset, 1'b1);
  endtask : t_timeout
  // rails drop and return: on-sense follows them
  task automatic t_sense;
    @(posedge core_clk) rails_ok <= 1'b0;
    wait_cyc(6);
    chk(supply_on_sense, 1'b0);
    chk(ctrl_reset, 1'b1);
    @(posedge core_clk) rails_ok <= 1'b1;
    wait_cyc(6);
    chk(supply_on_sense, 1'b1);
  endtask : t_sense
  // main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    t_short_high();
    t_power_up();
    t_glitch();
    t_park();
    t_timeout();
    t_sense();
    conclude();
  end
endmodule : tb_top
